// >>> pkg/lbs_defs.vh
`ifndef LBS_DEFS_VH
`define LBS_DEFS_VH
`define LBS_CLK_KHZ          250000
`define LBS_SW_FREQ_KHZ      1250
`define LBS_OVP_CYCLES       8
`define LBS_RETRY_US         12000
`define LBS_SHDN_LOW_US      2500
`define LBS_REF_MV           200
`define LBS_OFFSET_UV        750
`define LBS_SLOPE_DUTY_PCT   40
`define LBS_MIN_ON_NS        80
`define LBS_REF_W            16
`define LBS_REF_FULL         16'hFFFF
`define LBS_FILT_SHIFT       15
`define LBS_OFFSET_CODE      16'h00F6
`define LBS_SLOPE_STEP       16'h0040
`endif

// >>> verilog/lbs_sync3.v
`include "lbs_defs.vh"
module lbs_sync3 (
	input  wire clk_i,
	input  wire rst_i,
	input  wire d_i,
	output reg  q_o
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1  <= 1'b0;
			s2  <= 1'b0;
			s3  <= 1'b0;
			q_o <= 1'b0;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q_o <= s3;
		end
	end
endmodule // lbs_sync3

// >>> verilog/lbs_ref_filter.v
`include "lbs_defs.vh"
module lbs_ref_filter #(
	parameter W = `LBS_REF_W
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         step_i,
	input  wire         gate_i,
	output reg  [W-1:0] ref_o
);
	// first-order low pass of the chopped reference; level is set by duty, not amplitude
	wire [W-1:0] chopped = gate_i ? `LBS_REF_FULL : {W{1'b0}};
	reg  [W+15:0] acc;
	wire [W+15:0] chop_ext = {chopped, 16'h0000};
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc   <= {(W+16){1'b0}};
			ref_o <= {W{1'b0}};
		end else if (step_i) begin
			if (chop_ext >= acc)
				acc <= acc + ((chop_ext - acc) >> 8);
			else
				acc <= acc - ((acc - chop_ext) >> 8);
			ref_o <= acc[W+15:16];
		end
	end
endmodule // lbs_ref_filter

// >>> verilog/lbs_supervisor.v
`include "lbs_defs.vh"
// Notes on behaviour
// - switch runs from fixed 1.25 MHz clock, one on/off cycle per period
// - on-time ends when sensed current reaches error amplifier level
// - slope ramp is added to sensed current for duty above 40 percent
// - full brightness reference corresponds to 200 mV at feedback node
// - switch node overvoltage sampled once every switching cycle
// - eight consecutive overvoltage cycles turn the switch off
// - after a trip, switching resumes about 12 ms later, guard re-armed
// - enable shutdown holds from reset until enable goes high, otherwise starts only after enable input low continuously beyond 2.5 ms
// - in shutdown the switch stays off and never switches
// - enable held high applies full internal reference
// - reference passed while input high, blocked while low
// - chopped reference is low-pass filtered and used as regulation target
// - regulated level is duty times 200 mV plus 0.75 mV offset
// - dimmed level depends only on duty, not on logic high amplitude
// - supply under lockout threshold forces shutdown with switch off
// - restart only once supply exceeds threshold by hysteresis
// - thermal shutdown above 150 C, resume after 15 C fall
// - current limit ends on-time early that cycle
module lbs_supervisor #(
	parameter integer RETRY_CYCLES = (`LBS_RETRY_US * (`LBS_CLK_KHZ / 1000)),
	parameter integer SHDN_CYCLES  = (`LBS_SHDN_LOW_US * (`LBS_CLK_KHZ / 1000)),
	parameter integer OVP_CYCLES   = `LBS_OVP_CYCLES,
	parameter integer REF_W        = `LBS_REF_W
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             brightness_enable_input_i,
	input  wire             overvoltage_i,
	input  wire             current_limit_i,
	input  wire             supply_ok_i,
	input  wire             overtemp_i,
	input  wire [REF_W-1:0] error_amp_i,
	input  wire [REF_W-1:0] sense_current_i,
	output reg              power_switch_o,
	output reg              shutdown_o,
	output reg              guard_tripped_o,
	output reg  [REF_W-1:0] reg_reference_o,
	output reg              sw_cycle_o
);
	localparam integer PERIOD   = `LBS_CLK_KHZ / `LBS_SW_FREQ_KHZ;
	localparam integer MIN_ON   = (`LBS_MIN_ON_NS * (`LBS_CLK_KHZ / 1000) + 999) / 1000;
	localparam integer SLOPE_AT = (PERIOD * `LBS_SLOPE_DUTY_PCT) / 100;
	localparam [1:0] ST_OFF   = 2'd0;
	localparam [1:0] ST_RUN   = 2'd1;
	localparam [1:0] ST_RETRY = 2'd2;

	wire en_s;
	wire ovp_s;
	wire ilim_s;
	wire uv_ok_s;
	wire ot_s;
	lbs_sync3 u_en   (.clk_i(clk_i), .rst_i(rst_i), .d_i(brightness_enable_input_i), .q_o(en_s));
	lbs_sync3 u_ovp  (.clk_i(clk_i), .rst_i(rst_i), .d_i(overvoltage_i), .q_o(ovp_s));
	lbs_sync3 u_ilim (.clk_i(clk_i), .rst_i(rst_i), .d_i(current_limit_i), .q_o(ilim_s));
	lbs_sync3 u_uv   (.clk_i(clk_i), .rst_i(rst_i), .d_i(supply_ok_i), .q_o(uv_ok_s));
	lbs_sync3 u_ot   (.clk_i(clk_i), .rst_i(rst_i), .d_i(overtemp_i), .q_o(ot_s));

	// switching period divider
	reg  [7:0] phase;
	wire       cyc_start = (phase == 8'd0);
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			phase <= 8'd0;
		else if (phase == PERIOD[7:0] - 8'd1)
			phase <= 8'd0;
		else
			phase <= phase + 8'd1;
	end

	// brightness-low timer for shutdown
	reg [23:0] low_cnt;
	reg        en_shdn;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_cnt <= 24'h00_0000;
			en_shdn <= 1'b1;
		end else if (en_s) begin
			low_cnt <= 24'h00_0000;
			en_shdn <= 1'b0;
		end else if (low_cnt > SHDN_CYCLES[23:0]) begin
			en_shdn <= 1'b1;
		end else begin
			low_cnt <= low_cnt + 24'h00_0001;
		end
	end

	// supply and thermal lockouts; hysteresis lives in the analog comparators
	wire lockout = !uv_ok_s || ot_s;
	wire inhibit = lockout || en_shdn;

	// open-string guard
	reg [1:0]  state;
	reg [3:0]  ovp_cnt;
	reg [23:0] retry_cnt;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= ST_OFF;
			ovp_cnt   <= 4'h0;
			retry_cnt <= 24'h00_0000;
		end else begin
			case (state)
				ST_OFF: begin
					ovp_cnt <= 4'h0;
					if (!inhibit && cyc_start)
						state <= ST_RUN;
				end
				ST_RUN: begin
					if (inhibit) begin
						state <= ST_OFF;
					end else if (phase == PERIOD[7:0] - 8'd1) begin
						if (ovp_s) begin
							if (ovp_cnt == OVP_CYCLES[3:0] - 4'h1) begin
								state     <= ST_RETRY;
								retry_cnt <= 24'h00_0000;
								ovp_cnt   <= 4'h0;
							end else begin
								ovp_cnt <= ovp_cnt + 4'h1;
							end
						end else begin
							ovp_cnt <= 4'h0;
						end
					end
				end
				ST_RETRY: begin
					if (inhibit)
						state <= ST_OFF;
					else if (retry_cnt >= RETRY_CYCLES[23:0] - 24'h00_0001)
						state <= ST_OFF;
					else
						retry_cnt <= retry_cnt + 24'h00_0001;
				end
				default: state <= ST_OFF;
			endcase
		end
	end

	// reference chopping and filtering
	wire step = 1'b1;
	wire [REF_W-1:0] filt_ref;
	lbs_ref_filter #(.W(REF_W)) u_filt (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.step_i(step),
		.gate_i(en_s),
		.ref_o (filt_ref)
	);
	wire [REF_W:0] ref_sum = {1'b0, filt_ref} + {1'b0, `LBS_OFFSET_CODE};
	wire [REF_W-1:0] ref_sat = ref_sum[REF_W] ? `LBS_REF_FULL : ref_sum[REF_W-1:0];

	// current-mode pwm with slope compensation
	reg  [REF_W-1:0] slope;
	wire [REF_W:0]   sensed = {1'b0, sense_current_i} + {1'b0, slope};
	wire             trip   = (sensed >= {1'b0, error_amp_i});
	reg              on_phase;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slope    <= 16'h0000;
			on_phase <= 1'b0;
		end else begin
			if (cyc_start)
				slope <= 16'h0000;
			else if (phase >= SLOPE_AT[7:0])
				slope <= slope + `LBS_SLOPE_STEP;
			if (state != ST_RUN || inhibit)
				on_phase <= 1'b0;
			else if (cyc_start)
				on_phase <= 1'b1;
			else if (ilim_s && phase >= MIN_ON[7:0])
				on_phase <= 1'b0;
			else if (trip && phase >= MIN_ON[7:0])
				on_phase <= 1'b0;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			power_switch_o  <= 1'b0;
			shutdown_o      <= 1'b1;
			guard_tripped_o <= 1'b0;
			reg_reference_o <= 16'h0000;
			sw_cycle_o      <= 1'b0;
		end else begin
			power_switch_o  <= on_phase && state == ST_RUN && !inhibit;
			shutdown_o      <= inhibit;
			guard_tripped_o <= (state == ST_RETRY);
			reg_reference_o <= ref_sat;
			sw_cycle_o      <= cyc_start;
		end
	end
endmodule // lbs_supervisor

// >>> verification/lbs_properties.sv
module lbs_checker (
	input logic        clk_i,
	input logic        rst_i,
	input logic        brightness_enable_input_i,
	input logic        overvoltage_i,
	input logic        current_limit_i,
	input logic        supply_ok_i,
	input logic        overtemp_i,
	input logic        power_switch_o,
	input logic        shutdown_o,
	input logic        guard_tripped_o,
	input logic [15:0] reg_reference_o,
	input logic        sw_cycle_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_hold; guard_tripped_o [*8]; endsequence
	sequence s_ilim; $rose(power_switch_o) ##0 current_limit_i [*8]; endsequence
	// length of the current retry wait, cleared while the guard is idle
	logic [11:0] trip_len;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			trip_len <= 12'h000;
		else if (guard_tripped_o)
			trip_len <= trip_len + 12'h001;
		else
			trip_len <= 12'h000;
	end
	chk_shutdown_off: assert property (shutdown_o |-> !power_switch_o)
		else $error("switch on in shutdown");
	chk_trip_off: assert property (guard_tripped_o |-> !power_switch_o)
		else $error("switch on while tripped");
	chk_cycle_period: assert property (sw_cycle_o |-> ##200 sw_cycle_o)
		else $error("switching period wrong");
	chk_supply_off: assert property (!supply_ok_i [*6] |-> shutdown_o && !power_switch_o)
		else $error("runs on low supply");
	chk_thermal_off: assert property (overtemp_i [*6] |-> shutdown_o && !power_switch_o)
		else $error("runs while hot");
	chk_ref_rise: assert property (brightness_enable_input_i [*8] |=>
		reg_reference_o >= $past(reg_reference_o)) else $error("reference fell while high");
	chk_limit_end: assert property (s_ilim |-> ##[1:24] !power_switch_o)
		else $error("on-time not cut by limit");
	chk_trip_cause: assert property ($rose(guard_tripped_o) |-> $past(overvoltage_i))
		else $error("trip without overvoltage");
	chk_retry_span: assert property ($rose(guard_tripped_o) |-> s_hold)
		else $error("retry wait too short");
	chk_retry_len: assert property ($fell(guard_tripped_o) |->
		trip_len >= 12'd1900 && trip_len <= 12'd2010) else $error("retry wait wrong");
endmodule // lbs_checker
bind lbs_supervisor lbs_checker lbs_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
	.brightness_enable_input_i(brightness_enable_input_i), .overvoltage_i(overvoltage_i),
	.current_limit_i(current_limit_i), .supply_ok_i(supply_ok_i), .overtemp_i(overtemp_i),
	.power_switch_o(power_switch_o), .shutdown_o(shutdown_o), .guard_tripped_o(guard_tripped_o),
	.reg_reference_o(reg_reference_o), .sw_cycle_o(sw_cycle_o));

// >>> verification/lbs_host.sv
module lbs_host (
	input  logic        clk_i,
	input  logic        run_i,
	input  logic        lvl_i,
	input  logic [15:0] high_i,
	output logic        pwm_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int ph = 0;
	initial pwm_o = 1'b1;
	always @(negedge clk_i) begin
		ph <= (ph == 2499) ? 0 : ph + 1;
		pwm_o <= run_i ? (ph < high_i) : lvl_i;
	end
endmodule // lbs_host

// >>> verification/lbs_supervisor_tb.sv
module lbs_supervisor_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 0, rst_i = 1, ov = 0, il = 0, sok = 1, ot = 0, run = 0, lvl = 1;
	logic        pwm, psw, sd, gt, cyc;
	logic [15:0] hi = 16'h0000, rf;
	int          error_cnt = 0, tests_run = 0, i, n, m;
	lbs_host lbs_host_inst (.clk_i(clk_i), .run_i(run), .lvl_i(lvl), .high_i(hi), .pwm_o(pwm));
	lbs_supervisor #(.RETRY_CYCLES(2000), .SHDN_CYCLES(3000)) lbs_supervisor_inst (
		.clk_i(clk_i), .rst_i(rst_i), .brightness_enable_input_i(pwm), .overvoltage_i(ov),
		.current_limit_i(il), .supply_ok_i(sok), .overtemp_i(ot), .error_amp_i(16'h8000),
		.sense_current_i(16'h0000), .power_switch_o(psw), .shutdown_o(sd),
		.guard_tripped_o(gt), .reg_reference_o(rf), .sw_cycle_o(cyc));
	always #2 clk_i = ~clk_i;
	task tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task chk(input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (e !== g) begin
			error_cnt++;
			$display("CHECK FAILED %0t exp %h got %h", $time, e, g);
		end
	endtask
	task wgt(input logic v, input int k);
		for (i = 0; i < k && gt !== v; i++) tick(1);
	endtask
	task conclude;
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task t_run;
		il = 1;
		n = 0;
		m = 0;
		tick(300);
		for (i = 0; i < 1000; i++) begin
			tick(1);
			n += cyc;
			m += psw;
		end
		il = 0;
		chk(16'(n), 16'h0005);
		chk(16'(m > 80 && m < 126), 16'h0001);
	endtask
	task t_dim;
		run = 1;
		hi = 16'h04E2;
		tick(7500);
		chk(16'(sd), 16'h0000);
		hi = 16'h0003;
		tick(7500);
		chk(16'(sd), 16'h0000);
		run = 0;
		tick(2500);
		chk(16'(rf >= 16'hF000), 16'h0001);
		lvl = 0;
		tick(1500);
		chk(16'(rf < 16'h1000), 16'h0001);
		chk(16'(sd), 16'h0000);
		tick(1600);
		chk(16'({sd, psw}), 16'h0002);
		lvl = 1;
		tick(300);
		chk(16'(sd), 16'h0000);
	endtask
	task t_lock;
		for (n = 0; n < 2; n++) begin
			sok = n[0];
			ot = n[0];
			tick(20);
			chk(16'({sd, psw}), 16'h0002);
			sok = 1;
			ot = 0;
			tick(300);
			chk(16'(sd), 16'h0000);
		end
	endtask
	task t_ovp;
		ov = 1;
		tick(1390);
		chk(16'(gt), 16'h0000);
		wgt(1, 400);
		chk(16'({gt, psw}), 16'h0002);
		wgt(0, 2100);
		chk(16'(gt), 16'h0000);
		wgt(1, 1800);
		chk(16'(gt), 16'h0001);
		ov = 0;
		wgt(0, 2100);
		tick(400);
		chk(16'(gt), 16'h0000);
	endtask
	initial begin
		tick(12);
		rst_i = 0;
		t_run;
		t_dim;
		t_lock;
		t_ovp;
		conclude;
	end
	initial begin
		#300000;
		error_cnt++;
		conclude;
	end
endmodule // lbs_supervisor_tb
